/* File: shared/fhs_map.svh */
`ifndef FHS_MAP_SVH
`define FHS_MAP_SVH

// Clock and timing figures
`define FHS_CLK_FREQ_HZ      100000000
`define FHS_CLK_PERIOD_PS    10000
`define FHS_RESTART_MS       295
`define FHS_OC_HOLD_US       50
`define FHS_BLANK_NS         100
`define FHS_RESTART_CYCLES   ((`FHS_RESTART_MS * (`FHS_CLK_FREQ_HZ / 1000)))
`define FHS_OC_HOLD_CYCLES   ((`FHS_OC_HOLD_US * (`FHS_CLK_FREQ_HZ / 1000000)))
`define FHS_BLANK_CYCLES     \
    ((`FHS_BLANK_NS * 1000 + `FHS_CLK_PERIOD_PS - 1) / `FHS_CLK_PERIOD_PS)

// Soft-start discharge current in microamps
`define FHS_SS_DISCHARGE_UA  8'h28

`endif

/* File: shared/fhs_pkg.sv */
package fhs_pkg;
    typedef enum logic [2:0] {
        FHS_ST_FAULT,
        FHS_ST_RESET_WAIT,
        FHS_ST_SOFT_START,
        FHS_ST_RUN,
        FHS_ST_OC_DISCHARGE,
        FHS_ST_HICCUP
    } fhs_state_e;
endpackage

/* File: hw/fhs_supervisor.sv */
`timescale 1ns/1ps
`include "fhs_map.svh"

// Contract
// RULE1 - Input voltage outside the sense window is a shutdown fault.
// RULE2 - Overvoltage fault enters low-power mode for about 295 ms.
// RULE3 - After the delay, soft-start if cleared, else repeat the delay.
// RULE4 - Undervoltage shuts down with no low-power mode and no delay.
// RULE5 - Overcurrent shutdown is armed only after soft-start completes.
// RULE6 - Armed overcurrent stops charge and discharges soft-start at 40 uA.
// RULE7 - Each overcurrent retriggers a one-shot lasting 50 us past its end.
// RULE8 - Discharge is not cancelled while the one-shot is active.
// RULE9 - Soft-start below 4.375 V disables drive and fully discharges it.
// RULE10 - After overcurrent shutdown, 295 ms low power, then auto soft-start.
// RULE11 - Overcurrent ending 50 us before shutdown level restores charging.
// RULE12 - System may defeat hiccup by setting threshold above about 1.5 V.
// RULE13 - Current sense is ignored for the first 100 ns of each on-time.
// RULE14 - Blanking starts when the drive rising edge crosses 3.0 V.
// RULE15 - Blanking suppresses both the modulation and overcurrent compares.
// RULE16 - Fault on reference low, overvoltage, undervoltage or over-heat.
// RULE17 - During any fault, drive is disabled and soft-start discharged.
// RULE18 - Soft-start begins only when fault clear and soft-start reset low.
// RULE19 - Soft-start completes when soft-start exceeds error amp output.
// RULE20 - Blanking is disabled while feedback input is below 2.0 V.
// RULE21 - Comparator results arrive as synchronous flags; delays by counters.
// RULE22 - General fault shutdown takes priority over overcurrent sequence.
module fhs_supervisor
    import fhs_pkg::*;
#(
    parameter int RESTART_CYCLES = `FHS_RESTART_CYCLES,
    parameter int OC_HOLD_CYCLES = `FHS_OC_HOLD_CYCLES,
    parameter int BLANK_CYCLES   = `FHS_BLANK_CYCLES
) (
    input  wire logic CLK_SYS_IN,            // System clock, 100 MHz
    input  wire logic RST_IN,                // Async reset, active high
    input  wire logic OVERVOLTAGE_SENSE_IN,  // Overvoltage above 2.50 V
    input  wire logic UNDERVOLTAGE_SENSE_IN, // Undervoltage below 1.45 V
    input  wire logic VREF_LOW_IN,           // Reference below 4.65 V
    input  wire logic OVER_TEMP_IN,          // Die above about 130 C
    input  wire logic GATE_ABOVE_3V_IN,      // Drive output above 3.0 V
    input  wire logic FEEDBACK_INPUT_LOW_IN, // Feedback below 2.0 V
    input  wire logic PWM_CMP_IN,            // Raw peak-current compare
    input  wire logic OC_CMP_IN,             // Raw overcurrent compare
    input  wire logic SS_ABOVE_COMP_IN,      // Soft-start above error amp
    input  wire logic SS_BELOW_RESET_IN,     // Soft-start below reset level
    input  wire logic SS_BELOW_SHUT_IN,      // Soft-start below 4.375 V
    output logic      DRIVE_EN_OUT,          // Gate drive allowed
    output logic      SS_CHARGE_OUT,         // Soft-start charge source on
    output logic      SS_DISCH_40UA_OUT,     // 40 uA discharge on
    output logic      SS_DISCH_FAST_OUT,     // Fast full discharge on
    output logic      LOW_POWER_OUT,         // Low-power mode
    output logic      PWM_TRIP_OUT,          // Blanked peak-current compare
    output logic      OC_TRIP_OUT,           // Blanked overcurrent compare
    output logic      OC_ARMED_OUT,          // Soft-start done, OC armed
    output logic      OC_ONESHOT_OUT         // Overcurrent one-shot active
);

    // ==========================================================
    // Fault decode
    // ==========================================================
    fhs_state_e  state_reg;
    fhs_state_e  state_next;
    logic [31:0] delay_reg;
    logic [31:0] delay_next;
    logic [15:0] hold_reg;
    logic [7:0]  blank_reg;
    logic        gate_d_reg;

    // Count down by one, stopping at zero
    function automatic logic [31:0] count_down(input logic [31:0] value);
        return (value != 32'h0000_0000) ? value - 32'h0000_0001
                                        : 32'h0000_0000;
    endfunction

    wire window_fault = OVERVOLTAGE_SENSE_IN
                        | UNDERVOLTAGE_SENSE_IN;                  // [RULE1]
    wire any_fault = window_fault | VREF_LOW_IN | OVER_TEMP_IN;   // [RULE16]
    wire delay_done = (delay_reg == 32'h0000_0001);

    // ==========================================================
    // Leading edge blanking
    // ==========================================================
    wire gate_rise = GATE_ABOVE_3V_IN & ~gate_d_reg;              // [RULE14]
    wire blanking = (gate_rise | (blank_reg != 8'h00))
                    & ~FEEDBACK_INPUT_LOW_IN;                     // [RULE20]
    wire pwm_trip = PWM_CMP_IN & ~blanking;                       // [RULE15]
    wire oc_trip = OC_CMP_IN & ~blanking;                         // [RULE13]
    wire armed = (state_reg == FHS_ST_RUN)
                 | (state_reg == FHS_ST_OC_DISCHARGE);            // [RULE5]
    wire oc_event = oc_trip & armed;
    wire hold_active = oc_event | (hold_reg != 16'h0000);

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            gate_d_reg <= 1'b0;
            blank_reg  <= 8'h00;
        end else begin
            gate_d_reg <= GATE_ABOVE_3V_IN;
            if (gate_rise)
                blank_reg <= 8'(BLANK_CYCLES - 1);                // [RULE13]
            else
                blank_reg <= 8'(count_down({24'h00_0000, blank_reg}));
        end
    end

    // ==========================================================
    // Overcurrent one-shot, retriggered by each event
    // ==========================================================
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN)
            hold_reg <= 16'h0000;
        else if (oc_event)
            hold_reg <= 16'(OC_HOLD_CYCLES);                      // [RULE7]
        else
            hold_reg <= 16'(count_down({16'h0000, hold_reg}));   // [RULE21]
    end

    // ==========================================================
    // Supervisor state machine
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        delay_next = count_down(delay_reg);                       // [RULE21]
        if (any_fault && state_reg != FHS_ST_HICCUP) begin        // [RULE22]
            state_next = FHS_ST_FAULT;                            // [RULE17]
        end else begin
            case (state_reg)
                FHS_ST_FAULT: begin
                    state_next = FHS_ST_RESET_WAIT;
                end
                FHS_ST_RESET_WAIT: begin
                    if (SS_BELOW_RESET_IN)
                        state_next = FHS_ST_SOFT_START;           // [RULE18]
                end
                FHS_ST_SOFT_START: begin
                    if (SS_ABOVE_COMP_IN)
                        state_next = FHS_ST_RUN;                  // [RULE19]
                end
                FHS_ST_RUN: begin
                    if (oc_event)
                        state_next = FHS_ST_OC_DISCHARGE;         // [RULE6]
                end
                FHS_ST_OC_DISCHARGE: begin
                    if (SS_BELOW_SHUT_IN) begin
                        state_next = FHS_ST_HICCUP;               // [RULE9]
                        delay_next = 32'(RESTART_CYCLES);         // [RULE10]
                    end else if (!hold_active) begin
                        state_next = FHS_ST_RUN;                  // [RULE11]
                    end
                end
                FHS_ST_HICCUP: begin
                    if (delay_done) begin
                        if (any_fault)
                            delay_next = 32'(RESTART_CYCLES);     // [RULE3]
                        else
                            state_next = FHS_ST_RESET_WAIT;       // [RULE3]
                    end
                end
                default: state_next = FHS_ST_FAULT;
            endcase
        end
        // Overvoltage enters the timed low-power restart path
        if (OVERVOLTAGE_SENSE_IN && state_reg != FHS_ST_HICCUP) begin
            state_next = FHS_ST_HICCUP;                           // [RULE2]
            delay_next = 32'(RESTART_CYCLES);
        end
    end

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= FHS_ST_FAULT;
            delay_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            delay_reg <= delay_next;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    wire drive_next = (state_next == FHS_ST_SOFT_START)
                      | (state_next == FHS_ST_RUN)
                      | (state_next == FHS_ST_OC_DISCHARGE);
    wire disch_next = (state_next == FHS_ST_OC_DISCHARGE);        // [RULE8]
    wire fast_next = (state_next == FHS_ST_FAULT)
                     | (state_next == FHS_ST_RESET_WAIT)
                     | (state_next == FHS_ST_HICCUP);             // [RULE4]

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            DRIVE_EN_OUT      <= 1'b0;
            SS_CHARGE_OUT     <= 1'b0;
            SS_DISCH_40UA_OUT <= 1'b0;
            SS_DISCH_FAST_OUT <= 1'b1;
            LOW_POWER_OUT     <= 1'b0;
            PWM_TRIP_OUT      <= 1'b0;
            OC_TRIP_OUT       <= 1'b0;
            OC_ARMED_OUT      <= 1'b0;
            OC_ONESHOT_OUT    <= 1'b0;
        end else begin
            DRIVE_EN_OUT      <= drive_next;
            SS_CHARGE_OUT     <= drive_next & ~disch_next;
            SS_DISCH_40UA_OUT <= disch_next;
            SS_DISCH_FAST_OUT <= fast_next;
            LOW_POWER_OUT     <= (state_next == FHS_ST_HICCUP);   // [RULE2]
            PWM_TRIP_OUT      <= pwm_trip;
            OC_TRIP_OUT       <= oc_trip;
            OC_ARMED_OUT      <= armed;
            OC_ONESHOT_OUT    <= hold_active;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);

    a_fault_kills_drive: assert property ( // [RULE17]
        any_fault |=> !DRIVE_EN_OUT && !SS_CHARGE_OUT)
        else $error("drive on during fault");
    a_ov_low_power: assert property ( // [RULE2]
        OVERVOLTAGE_SENSE_IN |=> LOW_POWER_OUT)
        else $error("no low power on overvoltage");
    a_uv_no_low_power: assert property ( // [RULE4]
        UNDERVOLTAGE_SENSE_IN && !OVERVOLTAGE_SENSE_IN
        && state_reg != FHS_ST_HICCUP
        |=> !LOW_POWER_OUT)
        else $error("undervoltage entered low power");
    a_arm_after_ss: assert property ( // [RULE5]
        oc_event |-> state_reg == FHS_ST_RUN
                     || state_reg == FHS_ST_OC_DISCHARGE)
        else $error("overcurrent acted before soft-start done");
    a_oc_discharge: assert property ( // [RULE6]
        state_reg == FHS_ST_RUN && oc_event && !any_fault
        |=> SS_DISCH_40UA_OUT && !SS_CHARGE_OUT)
        else $error("no 40 uA discharge on overcurrent");
    a_hold_retrig: assert property ( // [RULE7]
        oc_event |=> hold_reg == 16'(OC_HOLD_CYCLES))
        else $error("one-shot not retriggered");
    a_no_cancel_hold: assert property ( // [RULE8]
        state_reg == FHS_ST_OC_DISCHARGE && hold_active
        |=> state_reg != FHS_ST_RUN)
        else $error("discharge cancelled during one-shot");
    a_shut_level: assert property ( // [RULE9]
        state_reg == FHS_ST_OC_DISCHARGE && SS_BELOW_SHUT_IN && !any_fault
        |=> state_reg == FHS_ST_HICCUP ##1 !DRIVE_EN_OUT)
        else $error("no shutdown at soft-start level");
    a_blank_masks: assert property ( // [RULE15]
        gate_rise && !FEEDBACK_INPUT_LOW_IN
        |=> !OC_TRIP_OUT && !PWM_TRIP_OUT)
        else $error("compare passed during blanking");
    a_blank_off_low_fb: assert property ( // [RULE20]
        FEEDBACK_INPUT_LOW_IN && PWM_CMP_IN |=> PWM_TRIP_OUT)
        else $error("blanking active with low feedback");
    a_reset_gate: assert property ( // [RULE18]
        state_reg == FHS_ST_RESET_WAIT && !SS_BELOW_RESET_IN
        |=> state_reg != FHS_ST_SOFT_START)
        else $error("soft-start above reset level");
    a_fault_fast_disch: assert property ( // [RULE17]
        any_fault |=> SS_DISCH_FAST_OUT)
        else $error("no fast discharge during fault");
    a_ss_done_run: assert property ( // [RULE19]
        state_reg == FHS_ST_SOFT_START && SS_ABOVE_COMP_IN && !any_fault
        |=> state_reg == FHS_ST_RUN)
        else $error("soft-start did not complete");
    a_oc_release: assert property ( // [RULE11]
        state_reg == FHS_ST_OC_DISCHARGE && !hold_active
        && !SS_BELOW_SHUT_IN && !any_fault
        |=> SS_CHARGE_OUT && !SS_DISCH_40UA_OUT)
        else $error("charging not restored after one-shot");
    a_hiccup_retry: assert property ( // [RULE3]
        state_reg == FHS_ST_HICCUP && delay_done && !any_fault
        |=> state_reg == FHS_ST_RESET_WAIT)
        else $error("no restart after delay");
    a_hiccup_drive_off: assert property ( // [RULE10]
        state_reg == FHS_ST_HICCUP |-> !DRIVE_EN_OUT)
        else $error("drive on during restart delay");
    a_uv_no_delay: assert property ( // [RULE4]
        state_reg == FHS_ST_FAULT && !any_fault
        |=> state_reg == FHS_ST_RESET_WAIT)
        else $error("delay after undervoltage clears");
    a_low_power_only: assert property ( // [RULE4]
        LOW_POWER_OUT |-> state_reg == FHS_ST_HICCUP)
        else $error("low power outside restart delay");
    a_oc_ignored_early: assert property ( // [RULE5]
        state_reg == FHS_ST_SOFT_START && !any_fault && !SS_ABOVE_COMP_IN
        |=> !SS_DISCH_40UA_OUT)
        else $error("overcurrent discharge during soft-start");

    // ==========================================================
    // Cover points
    // ==========================================================
    c_hiccup: cover property (
        state_reg == FHS_ST_OC_DISCHARGE ##1 state_reg == FHS_ST_HICCUP);
    c_oc_recover: cover property (
        state_reg == FHS_ST_OC_DISCHARGE ##1 state_reg == FHS_ST_RUN);
    c_ov_retry: cover property (
        state_reg == FHS_ST_HICCUP && delay_done && any_fault);
    c_run: cover property (state_reg == FHS_ST_RUN);
    c_uv_fault: cover property (
        UNDERVOLTAGE_SENSE_IN && state_reg == FHS_ST_RUN);

endmodule

/* File: tb/fhs_ss_model.sv */
`timescale 1ns/1ps
// ==============================
// Soft-start node and its level compares
module fhs_ss_model (
    input  wire logic clk_in,        // System clock
    input  wire logic rst_in,        // Async reset
    input  wire logic charge_in,     // Charge source on
    input  wire logic slow_in,       // 40 uA discharge on
    input  wire logic fast_in,       // Fast discharge on
    output logic      above_comp_out, // Above error amp
    output logic      below_reset_out, // Below reset level
    output logic      below_shut_out  // Below shutdown level
);
    int level;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in || fast_in) level <= 0;
        else if (slow_in && level > 0) level <= level - 1;
        else if (charge_in && level < 160) level <= level + 1;
    end
    // Compares settle as clocked flags
    assign above_comp_out  = (level > 120);
    assign below_reset_out = (level < 5);
    assign below_shut_out  = (level < 100);
endmodule

/* File: tb/test_fhs_supervisor.sv */
`timescale 1ns/1ps
module test_fhs_supervisor;
    import fhs_pkg::*;
    localparam int RC = 100;
    localparam int HC = 20;
    localparam int BC = 10;
    logic clk = 1'b0, rst = 1'b1, over_v = 1'b0, under_v = 1'b0;
    logic vref = 1'b0;
    logic hot = 1'b0, gate = 1'b0, fbl = 1'b0, pwm = 1'b0;
    logic oc = 1'b0; // Idle compare, as when defeated
    logic s_ab, s_rs, s_sh, drv, chg, d40, dfs, lp, ptr, otr, arm, one;
    int   errors = 0;
    int   n_checks = 0;
    int   t;
    always #5 clk = ~clk;
    fhs_supervisor #(.RESTART_CYCLES(RC), .OC_HOLD_CYCLES(HC),
        .BLANK_CYCLES(BC)) dut (
        .CLK_SYS_IN(clk), .RST_IN(rst), .OVERVOLTAGE_SENSE_IN(over_v),
        .UNDERVOLTAGE_SENSE_IN(under_v), .VREF_LOW_IN(vref),
        .OVER_TEMP_IN(hot), .GATE_ABOVE_3V_IN(gate),
        .FEEDBACK_INPUT_LOW_IN(fbl), .PWM_CMP_IN(pwm),
        .OC_CMP_IN(oc), .SS_ABOVE_COMP_IN(s_ab), .SS_BELOW_RESET_IN(s_rs),
        .SS_BELOW_SHUT_IN(s_sh), .DRIVE_EN_OUT(drv), .SS_CHARGE_OUT(chg),
        .SS_DISCH_40UA_OUT(d40), .SS_DISCH_FAST_OUT(dfs),
        .LOW_POWER_OUT(lp), .PWM_TRIP_OUT(ptr), .OC_TRIP_OUT(otr),
        .OC_ARMED_OUT(arm), .OC_ONESHOT_OUT(one));
    fhs_ss_model ss (.clk_in(clk), .rst_in(rst), .charge_in(chg),
        .slow_in(d40), .fast_in(dfs), .above_comp_out(s_ab),
        .below_reset_out(s_rs), .below_shut_out(s_sh));
    // ==============================
    // Shared tasks
    task automatic conclude();
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: check %0d got %b", $time, n_checks,
                got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // 0: armed, 1: low power on, 2: low power off
    task automatic wait_until(input int w, input int lim, output int took);
        for (took = 0; took < lim; took++) begin
            if ((w == 0 && arm === 1'b1) || (w == 1 && lp === 1'b1) ||
                (w == 2 && lp === 1'b0)) break;
            tick(1);
        end
        if (took == lim) begin
            errors++;
            $display("mismatch at %0t: wait ran out", $time);
            conclude();
        end
    endtask
    // ==============================
    // Scenarios
    initial begin
        tick(3);
        chk(dfs, 1'b1);
        chk(drv, 1'b0);
        chk(lp, 1'b0);
        @(posedge clk) begin rst <= 1'b0; oc <= 1'b1; end
        tick(20);
        chk(one, 1'b0);
        @(posedge clk) oc <= 1'b0;
        wait_until(0, 400, t);
        chk(drv, 1'b1);
        tick(50);
        @(posedge clk) oc <= 1'b1;
        @(posedge clk) oc <= 1'b0;
        tick(2);
        chk(d40, 1'b1);
        chk(chg, 1'b0);
        chk(one, 1'b1);
        tick(HC - 4);
        chk(d40, 1'b1);
        tick(8);
        chk(one, 1'b0);
        chk(chg, 1'b1);
        chk(drv, 1'b1);
        @(posedge clk) begin gate <= 1'b1; pwm <= 1'b1; oc <= 1'b1; end
        tick(4);
        chk(ptr, 1'b0);
        chk(otr, 1'b0);
        chk(one, 1'b0);
        @(posedge clk) oc <= 1'b0;
        tick(BC);
        chk(ptr, 1'b1);
        @(posedge clk) begin gate <= 1'b0; pwm <= 1'b0; fbl <= 1'b1; end
        tick(2);
        @(posedge clk) begin gate <= 1'b1; pwm <= 1'b1; end
        tick(3);
        chk(ptr, 1'b1);
        @(posedge clk) begin gate <= 1'b0; pwm <= 1'b0; fbl <= 1'b0; end
        tick(40);
        @(posedge clk) oc <= 1'b1;
        wait_until(1, 300, t);
        chk(drv, 1'b0);
        @(posedge clk) oc <= 1'b0;
        wait_until(2, RC + 20, t);
        chk(t >= RC - 3, 1'b1);
        wait_until(0, 400, t);
        @(posedge clk) under_v <= 1'b1;
        tick(3);
        chk(drv, 1'b0);
        chk(dfs, 1'b1);
        chk(lp, 1'b0);
        @(posedge clk) under_v <= 1'b0;
        wait_until(0, 300, t);
        for (int f = 0; f < 2; f++) begin
            tick(50);
            @(posedge clk) begin vref <= (f == 0); hot <= (f == 1);
                oc <= 1'b1; end
            tick(3);
            chk(drv, 1'b0);
            chk(dfs, 1'b1);
            chk(d40, 1'b0);
            @(posedge clk) begin vref <= 1'b0; hot <= 1'b0; oc <= 1'b0; end
            wait_until(0, 300, t);
        end
        tick(50);
        @(posedge clk) over_v <= 1'b1;
        tick(3);
        chk(lp, 1'b1);
        tick(RC + 20);
        chk(lp, 1'b1);
        @(posedge clk) over_v <= 1'b0;
        wait_until(2, RC + 20, t);
        wait_until(0, 300, t);
        tick(50);
        @(posedge clk) over_v <= 1'b1;
        @(posedge clk) over_v <= 1'b0;
        tick(3);
        wait_until(2, RC + 20, t);
        chk(t >= RC - 6, 1'b1);
        conclude();
    end
endmodule
